// *** sacs_conv.sv ***
// Internal successive-approximation conversion controller
`timescale 1ns/10ps
`default_nettype none
module sacs_conv
    import sacs_pkg::*;
#(
    parameter int RES_W       = RES_BITS,
    parameter int STEP_CYCLES = CONV_BIT_CYCLES
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             start,
    input  wire logic             cmp_keep,
    output logic [RES_W-1:0]      trial_code,
    output logic                  busy,
    output logic                  done,
    output logic [RES_W-1:0]      result
);

    typedef struct packed {
        sacs_conv_type    state;
        logic             cmp_s1;
        logic             cmp_s2;
        logic [RES_W-1:0] code;
        logic [RES_W-1:0] mask;
        logic [7:0]       wait_cnt;
        logic             done;
        logic [RES_W-1:0] result;
    } sacs_conv_st_type;

    sacs_conv_st_type st;
    sacs_conv_st_type next_st;

    localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);

    // Fixed-length bit trials, MSB first; result held until next completion
    always_comb begin
        next_st        = st;
        next_st.cmp_s1 = cmp_keep;
        next_st.cmp_s2 = st.cmp_s1;
        next_st.done   = 1'b0;
        unique case (st.state)
            CONV_IDLE: begin
                if (start) begin
                    next_st.state    = CONV_TRIAL;
                    next_st.mask     = {1'b1, {(RES_W-1){1'b0}}};
                    next_st.code     = {1'b1, {(RES_W-1){1'b0}}};
                    next_st.wait_cnt = 8'h00;
                end
            end
            CONV_TRIAL: begin
                if (st.wait_cnt == STEP_LAST) begin
                    next_st.wait_cnt = 8'h00;
                    next_st.mask     = st.mask >> 1;
                    next_st.code     = (st.cmp_s2 ? st.code : (st.code & ~st.mask)) | (st.mask >> 1);
                    if (st.mask[0]) begin
                        next_st.result = st.cmp_s2 ? st.code : (st.code & ~st.mask);
                        next_st.done   = 1'b1;
                        next_st.state  = CONV_DONE;
                    end
                end else begin
                    next_st.wait_cnt = st.wait_cnt + 8'h01;
                end
            end
            CONV_DONE: begin
                next_st.state = CONV_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{state: CONV_IDLE, cmp_s1: 1'b0, cmp_s2: 1'b0, code: '0, mask: '0,
                    wait_cnt: 8'h00, done: 1'b0, result: RESULT_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign trial_code = st.code;
    assign busy       = st.state[1]; // High while trials run
    assign done       = st.done;
    assign result     = st.result;

endmodule // sacs_conv
`default_nettype wire

// *** sacs_host_model.sv ***
// Host serial port model driving select, shift clock and address
`timescale 1ns/10ps
`default_nettype none
module sacs_host_model (
    input  wire logic clk_sys,
    input  wire logic data_out,
    output logic      cs_b,
    output logic      io_clk,
    output logic      addr_in
);
    // Deselected, clock standing low
    initial begin
        cs_b    = 1'b1;
        io_clk  = 1'b0;
        addr_in = 1'b0;
    end

    // One 800 ns shift clock; result bit read late in the high phase
    task automatic pulse(input logic a, output logic d);
        @(posedge clk_sys);
        io_clk  <= 1'b0;
        addr_in <= a;
        repeat (4) @(posedge clk_sys);
        io_clk <= 1'b1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        d = data_out;
    endtask

    // Return the shift clock to its idle low level
    task automatic idle;
        @(posedge clk_sys);
        io_clk <= 1'b0;
    endtask

    // Whole transfer: address MSB first, then filler that keeps changing
    task automatic xfer(input logic [3:0] addr, input int nclk, input logic hold_low,
                        output logic [9:0] got, output logic extra);
        logic d;
        got   = 10'h000;
        extra = 1'b0;
        if (cs_b === 1'b1) begin
            @(posedge clk_sys);
            cs_b <= 1'b0;
            repeat (8) @(posedge clk_sys);
        end
        for (int i = 0; i < nclk; i++) begin
            pulse((i < 4) ? addr[3 - i] : ~addr_in, d);
            if (i < 10) got[9 - i] = d;
            else extra = extra | d;
        end
        @(posedge clk_sys);
        io_clk <= 1'b0;
        if (hold_low !== 1'b1) begin
            repeat (4) @(posedge clk_sys);
            cs_b <= 1'b1;
        end
    endtask
endmodule // sacs_host_model
`default_nettype wire

// *** sacs_pkg.sv ***
// Shared constants and types for the serial ADC conversion sequencer
package sacs_pkg;

    // Result, address and edge-counter widths
    localparam int RES_BITS  = 10;
    localparam int ADDR_BITS = 4;
    localparam int CNT_BITS  = 5;

    // Shift-clock edge counts that mark the phases of a transfer
    localparam logic [4:0] ADDR_EDGES  = 5'h04;
    localparam logic [4:0] SAMPLE_FALL = 5'h04;
    localparam logic [4:0] HOLD_FALL   = 5'h0A;
    localparam logic [4:0] LAST_FALL   = 5'h10;

    // Channel address codes
    localparam logic [3:0] EXT_LAST_CODE  = 4'hA;
    localparam logic [3:0] TEST_HALF_CODE = 4'hB;
    localparam logic [3:0] TEST_LOW_CODE  = 4'hC;
    localparam logic [3:0] TEST_HIGH_CODE = 4'hD;

    // Values after reset
    localparam logic       EOC_RESET    = 1'b1;
    localparam logic [9:0] RESULT_RESET = 10'h000;

    // Conversion timing: each bit trial takes a least settling time
    localparam int CLK_PERIOD_NS   = 100;
    localparam int CONV_BIT_NS     = 400;
    localparam int CONV_BIT_CYCLES = (CONV_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Serial sequence states
    typedef enum logic [2:0] {
        SEQ_OFF   = 3'b001,
        SEQ_SHIFT = 3'b010,
        SEQ_TAIL  = 3'b100
    } sacs_seq_type;

    // Conversion controller states
    typedef enum logic [2:0] {
        CONV_IDLE  = 3'b001,
        CONV_TRIAL = 3'b010,
        CONV_DONE  = 3'b100
    } sacs_conv_type;

endpackage : sacs_pkg

// *** sacs_seq.sv ***
// Serial interface and conversion sequencer of a 10-bit SAR converter
`timescale 1ns/10ps
`default_nettype none
module sacs_seq
    import sacs_pkg::*;
#(
    parameter int STEP_CYCLES = CONV_BIT_CYCLES
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    input  wire logic                 cs_b,
    input  wire logic                 io_clk,
    input  wire logic                 addr_in,
    input  wire logic                 cmp_keep,
    output logic                      data_out,
    output logic                      data_out_oe,
    output logic                      eoc,
    output logic [ADDR_BITS-1:0]      chan_sel,
    output logic                      chan_valid,
    output logic                      ext_sel,
    output logic [2:0]                test_sel,
    output logic                      sample_en,
    output logic [RES_BITS-1:0]       dac_code
);

    typedef struct packed {
        sacs_seq_type          seq;
        logic                  cs_s1;
        logic                  cs_s2;
        logic                  cs_prev;
        logic                  ck_s1;
        logic                  ck_s2;
        logic                  ck_prev;
        logic                  ad_s1;
        logic                  ad_s2;
        logic [CNT_BITS-1:0]   rcnt;
        logic [CNT_BITS-1:0]   fcnt;
        logic [ADDR_BITS-1:0]  addr_sh;
        logic [ADDR_BITS-1:0]  chan;
        logic                  chan_valid;
        logic                  ext_sel;
        logic [2:0]            test_sel;
        logic                  sample_en;
        logic [RES_BITS-1:0]   shreg;
        logic                  dout;
        logic                  oe;
        logic                  eoc;
        logic                  conv_start;
    } sacs_seq_st_type;

    sacs_seq_st_type         st;
    sacs_seq_st_type         next_st;
    logic                    conv_done;
    logic [RES_BITS-1:0]     conv_result;

    // Maps a channel code onto the three test-voltage selects
    function automatic logic [2:0] test_decode(input logic [3:0] code);
        logic [2:0] sel;
        sel = 3'h0;
        if (code == TEST_HALF_CODE) sel = 3'h1;
        if (code == TEST_LOW_CODE)  sel = 3'h2;
        if (code == TEST_HIGH_CODE) sel = 3'h4;
        return sel;
    endfunction

    // Saturating shift-clock edge counter step
    function automatic logic [4:0] count_up(input logic [4:0] cnt);
        return (cnt == LAST_FALL) ? cnt : cnt + 5'h01;
    endfunction

    // Sequencer: synchronisers, edge detection, address, sampling, result shift
    always_comb begin
        logic       cs_act;
        logic       cs_fall;
        logic       ck_rise;
        logic       ck_fall;
        logic       start_seq;
        logic [4:0] fnew;
        cs_act    = 1'b0;
        cs_fall   = 1'b0;
        ck_rise   = 1'b0;
        ck_fall   = 1'b0;
        start_seq = 1'b0;
        fnew      = 5'h00;

        next_st            = st;
        next_st.cs_s1      = cs_b;
        next_st.cs_s2      = st.cs_s1;
        next_st.cs_prev    = st.cs_s2;
        next_st.ck_s1      = io_clk;
        next_st.ck_s2      = st.ck_s1;
        next_st.ck_prev    = st.ck_s2;
        next_st.ad_s1      = addr_in;
        next_st.ad_s2      = st.ad_s1;
        next_st.conv_start = 1'b0;

        cs_act  = ~st.cs_s2;
        cs_fall = st.cs_prev & ~st.cs_s2;
        ck_rise = ~st.ck_prev & st.ck_s2;
        ck_fall = st.ck_prev & ~st.ck_s2;
        fnew    = count_up(st.fcnt);

        // Done output follows the conversion controller
        if (conv_done) begin
            next_st.eoc = 1'b1;
        end

        unique case (st.seq)
            SEQ_OFF: begin
                next_st.oe        = 1'b0;
                next_st.sample_en = 1'b0;
                if (cs_fall) begin
                    start_seq = 1'b1;
                end
            end
            SEQ_SHIFT: begin
                if (ck_rise && st.rcnt < ADDR_EDGES) begin
                    next_st.addr_sh = {st.addr_sh[ADDR_BITS-2:0], st.ad_s2};
                    next_st.rcnt    = st.rcnt + 5'h01;
                    if (st.rcnt == ADDR_EDGES - 5'h01) begin
                        next_st.chan       = {st.addr_sh[ADDR_BITS-2:0], st.ad_s2};
                        next_st.chan_valid = 1'b1;
                        next_st.ext_sel    = ({st.addr_sh[ADDR_BITS-2:0], st.ad_s2} <= EXT_LAST_CODE);
                        next_st.test_sel   = test_decode({st.addr_sh[ADDR_BITS-2:0], st.ad_s2});
                    end
                end
                if (ck_fall) begin
                    next_st.fcnt = fnew;
                    if (fnew == SAMPLE_FALL) begin
                        next_st.sample_en = 1'b1;
                    end
                    if (fnew < HOLD_FALL) begin
                        next_st.dout  = st.shreg[RES_BITS-2];
                        next_st.shreg = {st.shreg[RES_BITS-2:0], 1'b0};
                    end else begin
                        next_st.dout       = 1'b0;
                        next_st.sample_en  = 1'b0;
                        next_st.conv_start = 1'b1;
                        next_st.eoc        = 1'b0;
                        next_st.seq        = SEQ_TAIL;
                    end
                end
            end
            SEQ_TAIL: begin
                next_st.dout = 1'b0;
                if (ck_fall) begin
                    next_st.fcnt = fnew;
                    if (fnew == LAST_FALL && (st.eoc || conv_done)) begin
                        start_seq = 1'b1;
                    end
                end
                if (conv_done && (st.fcnt == HOLD_FALL || st.fcnt == LAST_FALL)) begin
                    start_seq = 1'b1;
                end
            end
        endcase

        // New sequence: counters cleared, previous result loaded, MSB driven
        if (start_seq) begin
            next_st.seq        = SEQ_SHIFT;
            next_st.rcnt       = 5'h00;
            next_st.fcnt       = 5'h00;
            next_st.chan_valid = 1'b0;
            next_st.sample_en  = 1'b0;
            next_st.shreg      = conv_result;
            next_st.dout       = conv_result[RES_BITS-1];
            next_st.oe         = 1'b1;
        end

        // Select inactive overrides the sequence state, output enable and sample enable
        if (!cs_act) begin
            next_st.seq       = SEQ_OFF;
            next_st.oe        = 1'b0;
            next_st.sample_en = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{seq: SEQ_OFF, cs_s1: 1'b1, cs_s2: 1'b1, cs_prev: 1'b1,
                    ck_s1: 1'b0, ck_s2: 1'b0, ck_prev: 1'b0, ad_s1: 1'b0, ad_s2: 1'b0,
                    rcnt: 5'h00, fcnt: 5'h00, addr_sh: 4'h0, chan: 4'h0, chan_valid: 1'b0,
                    ext_sel: 1'b0, test_sel: 3'h0, sample_en: 1'b0, shreg: RESULT_RESET,
                    dout: 1'b0, oe: 1'b0, eoc: EOC_RESET, conv_start: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // Internal conversion controller on the system clock
    sacs_conv #(
        .RES_W       (RES_BITS),
        .STEP_CYCLES (STEP_CYCLES)
    ) u_conv (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .start      (st.conv_start),
        .cmp_keep   (cmp_keep),
        .trial_code (dac_code),
        .busy       (),
        .done       (conv_done),
        .result     (conv_result)
    );

    // Outputs straight from state flops
    assign data_out    = st.dout;
    assign data_out_oe = st.oe;
    assign eoc         = st.eoc;
    assign chan_sel    = st.chan;
    assign chan_valid  = st.chan_valid;
    assign ext_sel     = st.ext_sel;
    assign test_sel    = st.test_sel;
    assign sample_en   = st.sample_en;

endmodule // sacs_seq
`default_nettype wire

// *** sacs_seq_checker.sv ***
// Port assertions for the serial ADC conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module sacs_seq_checker
    import sacs_pkg::*;
#(
    parameter int STEP_CYCLES = CONV_BIT_CYCLES
) (
    input wire logic                 clk_sys,
    input wire logic                 rst_b,
    input wire logic                 cs_b,
    input wire logic                 io_clk,
    input wire logic                 addr_in,
    input wire logic                 cmp_keep,
    input wire logic                 data_out,
    input wire logic                 data_out_oe,
    input wire logic                 eoc,
    input wire logic [ADDR_BITS-1:0] chan_sel,
    input wire logic                 chan_valid,
    input wire logic                 ext_sel,
    input wire logic [2:0]           test_sel,
    input wire logic                 sample_en,
    input wire logic [RES_BITS-1:0]  dac_code
);
    // Window for the fixed conversion time
    localparam int EOC_MIN = 10 * STEP_CYCLES - 2;
    localparam int EOC_MAX = 10 * STEP_CYCLES + 8;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    AST_IDLE_HIZ: assert property (cs_b [*6] |-> !data_out_oe)
        else $error("output driven while deselected");
    AST_SEL_DRIVE: assert property ($fell(cs_b) |-> ##[2:6] data_out_oe)
        else $error("output not enabled after select");
    AST_SEL_HOLD: assert property (!cs_b [*8] |-> data_out_oe)
        else $error("output dropped while selected");
    AST_TENTH_FALL: assert property ($fell(eoc) |-> $fell(sample_en) && !data_out)
        else $error("tenth fall actions not together");
    AST_CONV_BUSY: assert property ($fell(eoc) |-> (!eoc) throughout (##EOC_MIN 1))
        else $error("done returned too early");
    AST_CONV_END: assert property ($fell(eoc) |-> ##[EOC_MIN:EOC_MAX] eoc)
        else $error("done not returned in time");
    AST_SAMPLE_SPAN: assert property ($rose(sample_en) |-> ##[44:52] $fell(sample_en))
        else $error("sample window length wrong");
    AST_NO_SAMPLE_BUSY: assert property (!eoc |-> !sample_en)
        else $error("sampling during conversion");
    AST_MUX_DECODE: assert property ($rose(chan_valid) |=> (ext_sel == (chan_sel <= EXT_LAST_CODE))
        && (test_sel == {chan_sel == TEST_HIGH_CODE, chan_sel == TEST_LOW_CODE, chan_sel == TEST_HALF_CODE}))
        else $error("channel decode wrong");
    AST_CHAN_KEEP: assert property (chan_valid && $past(chan_valid) |-> $stable(chan_sel))
        else $error("channel changed after address");
    // Hold of the sample while selected always takes done low with it
    AST_TENTH_DONE: assert property ($fell(sample_en) && !cs_b |-> $fell(eoc))
        else $error("done not lowered at tenth fall");
    // Trial code only moves while a conversion runs
    AST_DAC_QUIET: assert property (eoc && $past(eoc) |-> $stable(dac_code))
        else $error("trial code moved while done");

    // Main scenarios
    COV_HELD_LOW: cover property ($rose(eoc) && !cs_b);
    COV_SELECT: cover property ($fell(cs_b));
    COV_TEST_CHAN: cover property ($rose(chan_valid) ##1 test_sel != 3'h0);
endmodule // sacs_seq_checker

bind sacs_seq sacs_seq_checker #(.STEP_CYCLES(STEP_CYCLES)) i_sacs_seq_checker (.clk_sys(clk_sys), .rst_b(rst_b),
    .cs_b(cs_b), .io_clk(io_clk), .addr_in(addr_in), .cmp_keep(cmp_keep), .data_out(data_out),
    .data_out_oe(data_out_oe), .eoc(eoc), .chan_sel(chan_sel), .chan_valid(chan_valid), .ext_sel(ext_sel),
    .test_sel(test_sel), .sample_en(sample_en), .dac_code(dac_code));
`default_nettype wire

// *** sacs_seq_tb.sv ***
// Self-checking bench for the serial ADC conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module sacs_seq_tb
    import sacs_pkg::*;
;
    typedef struct packed {
        logic [3:0] addr;
        logic [9:0] vin;
        logic [4:0] nclk;
        logic       ext;
        logic [2:0] test;
    } sacs_row_type;

    logic         clk_sys = 1'b0;
    logic         rst_b   = 1'b0;
    logic         cmp_keep = 1'b0;
    logic [9:0]   vin     = 10'h000;
    wire          cs_b, io_clk, addr_in;
    logic         data_out, data_out_oe, eoc, chan_valid, ext_sel, sample_en;
    logic [3:0]   chan_sel;
    logic [2:0]   test_sel;
    logic [9:0]   dac_code, got, prev;
    logic         extra, d;
    // Host sees the inverse of the last bit while the output floats
    wire          line_dout = data_out_oe ? data_out : ~data_out;
    int           miscompares = 0;
    int           num_checks  = 0;
    sacs_row_type rows [6];
    logic [9:0]   held [3];

    sacs_seq #(.STEP_CYCLES(CONV_BIT_CYCLES)) i_sacs_seq (.clk_sys(clk_sys), .rst_b(rst_b), .cs_b(cs_b),
        .io_clk(io_clk), .addr_in(addr_in), .cmp_keep(cmp_keep), .data_out(data_out), .data_out_oe(data_out_oe),
        .eoc(eoc), .chan_sel(chan_sel), .chan_valid(chan_valid), .ext_sel(ext_sel), .test_sel(test_sel),
        .sample_en(sample_en), .dac_code(dac_code));
    sacs_host_model i_sacs_host_model (.clk_sys(clk_sys), .data_out(line_dout), .cs_b(cs_b), .io_clk(io_clk),
        .addr_in(addr_in));

    // 10 MHz clock
    always #50 clk_sys = ~clk_sys;

    // Comparator: keep the trial bit while the input is not below it
    always @(posedge clk_sys) cmp_keep <= (dac_code <= vin);

    task automatic check(input logic ok, input string what);
        num_checks++;
        if (ok !== 1'b1) begin
            $display("unexpected at %0t: %s", $time, what);
            miscompares++;
        end
    endtask

    // Bounded wait for conversion done, after the tenth fall has landed
    task automatic wait_eoc;
        repeat (8) @(negedge clk_sys);
        for (int n = 0; n < 200 && eoc !== 1'b1; n++) @(negedge clk_sys);
        check(eoc === 1'b1, "done missing");
    endtask

    task automatic final_report;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #1000000;
        miscompares++;
        final_report();
    end

    // Main sequence
    initial begin
        rows = '{'{4'h0, 10'h3FF, 5'h0A, 1'b1, 3'h0}, '{4'hA, 10'h000, 5'h10, 1'b1, 3'h0},
                 '{4'hB, 10'h200, 5'h0B, 1'b0, 3'h1}, '{4'hC, 10'h155, 5'h0D, 1'b0, 3'h2},
                 '{4'hD, 10'h2AA, 5'h0A, 1'b0, 3'h4}, '{4'hF, 10'h001, 5'h0C, 1'b0, 3'h0}};
        held = '{10'h2C3, 10'h0F0, 10'h3C0};
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(negedge clk_sys);
        check(eoc === EOC_RESET && data_out_oe === 1'b0 && chan_valid === 1'b0, "reset values");
        for (int i = 0; i < 3; i++) i_sacs_host_model.pulse(1'b1, d);
        i_sacs_host_model.idle();
        repeat (4) @(negedge clk_sys);
        check(chan_valid === 1'b0 && data_out_oe === 1'b0, "active while deselected");
        prev = RESULT_RESET;
        foreach (rows[i]) begin
            @(posedge clk_sys) vin <= rows[i].vin;
            i_sacs_host_model.xfer(rows[i].addr, int'(rows[i].nclk), 1'b0, got, extra);
            check(got === prev, "result bits");
            check(extra === 1'b0, "bits past tenth");
            wait_eoc();
            check(chan_sel === rows[i].addr && ext_sel === rows[i].ext, "channel");
            check(test_sel === rows[i].test, "test voltage");
            check(data_out_oe === 1'b0, "driving after deselect");
            prev = rows[i].vin;
        end
        // Select held low for a ten- and a sixteen-clock transfer, then released
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys) vin <= held[k];
            i_sacs_host_model.xfer(4'(k + 3), (k == 1) ? 16 : 10, k < 2, got, extra);
            check(got === prev, "held select result");
            check(extra === 1'b0, "held bits past tenth");
            wait_eoc();
            if (k < 2) check(data_out === held[k][9] && data_out_oe === 1'b1, "msb at done");
            else check(data_out_oe === 1'b0, "driving after release");
            prev = held[k];
        end
        // Reset in mid-conversion clears the stored result
        i_sacs_host_model.xfer(4'h2, 10, 1'b0, got, extra);
        @(negedge clk_sys);
        check(eoc === 1'b0, "done high during conversion");
        @(posedge clk_sys) rst_b <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(negedge clk_sys);
        check(eoc === EOC_RESET && data_out_oe === 1'b0 && chan_valid === 1'b0 && dac_code === 10'h000,
              "mid-run reset values");
        i_sacs_host_model.xfer(4'h1, 10, 1'b0, got, extra);
        check(got === RESULT_RESET, "result after mid-run reset");
        wait_eoc();
        final_report();
    end
endmodule // sacs_seq_tb
`default_nettype wire
